/* core/touch_gesture_recognizer.sv */
// Top level: register slave, sample tick and gesture interrupt
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
module touch_gesture_recognizer #(
  parameter int unsigned TICK_CYCLES = gesture_pkg::SAMPLE_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic touched_i,
  input wire logic [gesture_pkg::POS_W-1:0] position_i,
  output logic sample_tick_o,
  output logic [gesture_pkg::EV_W-1:0] gesture_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  gesture_pkg::gest_cfg_t cfg_reg;
  logic enable_reg;                            // Recognizer enable
  logic [gesture_pkg::EV_W-1:0] status_reg;    // Sticky gesture flags
  logic [gesture_pkg::EV_W-1:0] mask_reg;      // Interrupt mask
  logic [31:0] tick_div_reg;                   // Sample period in clocks
  logic [31:0] tick_cnt_reg;                   // Sample period counter
  logic tick_reg;                              // One-cycle sample tick
  logic [31:0] rdata_reg;

  wire logic [gesture_pkg::EV_W-1:0] events;
  gesture_pkg::gest_state_t state;
  gesture_pkg::gest_sample_t sample;

  assign sample.touched = touched_i;
  assign sample.position = position_i;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire logic sel_min_touch = addr_i == gesture_pkg::ADDR_MIN_TOUCH;
  wire logic sel_max_touch = addr_i == gesture_pkg::ADDR_MAX_TOUCH;
  wire logic sel_window = addr_i == gesture_pkg::ADDR_TAP_WINDOW;
  wire logic sel_min_hold = addr_i == gesture_pkg::ADDR_MIN_HOLD;
  wire logic sel_max_swipe = addr_i == gesture_pkg::ADDR_MAX_SWIPE;
  wire logic sel_motion = addr_i == gesture_pkg::ADDR_MOTION_START;
  wire logic sel_swipe = addr_i == gesture_pkg::ADDR_SWIPE_TRAVEL;
  wire logic sel_slide = addr_i == gesture_pkg::ADDR_SLIDE_STEP;
  wire logic sel_ctrl = addr_i == gesture_pkg::ADDR_CTRL;
  wire logic sel_status = addr_i == gesture_pkg::ADDR_STATUS;
  wire logic sel_mask = addr_i == gesture_pkg::ADDR_MASK;
  wire logic sel_state = addr_i == gesture_pkg::ADDR_STATE;
  wire logic sel_div = addr_i == gesture_pkg::ADDR_SAMPLE_DIV;

  // Read multiplexer; unmapped addresses read zero
  logic [31:0] rd_mux;
  assign rd_mux =
    sel_min_touch ? {24'h00_0000, cfg_reg.min_touch_samples} :
    sel_max_touch ? {24'h00_0000, cfg_reg.max_touch_samples} :
    sel_window ? {24'h00_0000, cfg_reg.second_tap_window_samples} :
    sel_min_hold ? {24'h00_0000, cfg_reg.min_hold_samples} :
    sel_max_swipe ? {24'h00_0000, cfg_reg.max_swipe_samples} :
    sel_motion ? {20'h0_0000, cfg_reg.motion_start_distance} :
    sel_swipe ? {20'h0_0000, cfg_reg.min_swipe_travel} :
    sel_slide ? {20'h0_0000, cfg_reg.slide_step_distance} :
    sel_ctrl ? {29'h0000_0000, cfg_reg.positional, cfg_reg.double_tap_en, enable_reg} :
    sel_status ? {25'h000_0000, status_reg} :
    sel_mask ? {25'h000_0000, mask_reg} :
    sel_state ? {29'h0000_0000, state} :
    sel_div ? tick_div_reg :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_reg.min_touch_samples <= gesture_pkg::RST_MIN_TOUCH;
      cfg_reg.max_touch_samples <= gesture_pkg::RST_MAX_TOUCH;
      cfg_reg.second_tap_window_samples <= gesture_pkg::RST_TAP_WINDOW;
      cfg_reg.min_hold_samples <= gesture_pkg::RST_MIN_HOLD;
      cfg_reg.max_swipe_samples <= gesture_pkg::RST_MAX_SWIPE;
      cfg_reg.motion_start_distance <= gesture_pkg::RST_MOTION_START;
      cfg_reg.min_swipe_travel <= gesture_pkg::RST_SWIPE_TRAVEL;
      cfg_reg.slide_step_distance <= gesture_pkg::RST_SLIDE_STEP;
      enable_reg <= gesture_pkg::RST_CTRL[gesture_pkg::CTRL_ENABLE_BIT];
      cfg_reg.double_tap_en <= gesture_pkg::RST_CTRL[gesture_pkg::CTRL_DOUBLE_TAP_BIT];
      cfg_reg.positional <= gesture_pkg::RST_CTRL[gesture_pkg::CTRL_POSITIONAL_BIT];
      mask_reg <= '0;
      tick_div_reg <= TICK_CYCLES;
    end else if (wr_i) begin
      if (sel_min_touch) begin
        cfg_reg.min_touch_samples <= wdata_i[7:0];
      end else if (sel_max_touch) begin
        cfg_reg.max_touch_samples <= wdata_i[7:0];
      end else if (sel_window) begin
        cfg_reg.second_tap_window_samples <= wdata_i[7:0];
      end else if (sel_min_hold) begin
        cfg_reg.min_hold_samples <= wdata_i[7:0];
      end else if (sel_max_swipe) begin
        cfg_reg.max_swipe_samples <= wdata_i[7:0];
      end else if (sel_motion) begin
        cfg_reg.motion_start_distance <= wdata_i[11:0];
      end else if (sel_swipe) begin
        cfg_reg.min_swipe_travel <= wdata_i[11:0];
      end else if (sel_slide) begin
        cfg_reg.slide_step_distance <= wdata_i[11:0];
      end else if (sel_ctrl) begin
        enable_reg <= wdata_i[gesture_pkg::CTRL_ENABLE_BIT];
        cfg_reg.double_tap_en <= wdata_i[gesture_pkg::CTRL_DOUBLE_TAP_BIT];
        cfg_reg.positional <= wdata_i[gesture_pkg::CTRL_POSITIONAL_BIT];
      end else if (sel_mask) begin
        mask_reg <= wdata_i[gesture_pkg::EV_W-1:0];
      end else if (sel_div) begin
        // Zero is stored as one; both give a tick every clock
        tick_div_reg <= (wdata_i == 32'h0000_0000) ? 32'h0000_0001 : wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status: new events win over a write-one clear
  wire logic [gesture_pkg::EV_W-1:0] clr_bits = (wr_i && sel_status) ? wdata_i[gesture_pkg::EV_W-1:0] : '0;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~clr_bits) | events;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample tick divider, 20 ms by default
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg + 32'h0000_0001 >= tick_div_reg) begin
      tick_cnt_reg <= '0;
      tick_reg <= enable_reg;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data register, valid the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_reg <= '0;
    end else if (rd_i) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gesture engine
  gesture_engine u_engine (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tick_i(tick_reg),
    .sample_i(sample),
    .cfg_i(cfg_reg),
    .events_o(events),
    .state_o(state)
  );

  assign rdata_o = rdata_reg;
  assign sample_tick_o = tick_reg;
  assign gesture_o = events;
  assign irq_o = |(status_reg & mask_reg);

endmodule

/* core/gesture_pkg.sv */
// Package: constants, types and register map of the touch gesture recognizer
package gesture_pkg;

  // Sample period and system clock
  localparam int unsigned SAMPLE_PERIOD_MS = 20;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SAMPLE_RATE_HZ = 1000 / SAMPLE_PERIOD_MS;
  localparam int unsigned SAMPLE_TICK_CYCLES = (CLK_HZ / 1000) * SAMPLE_PERIOD_MS;

  // Widths
  localparam int unsigned CNT_W = 8;
  localparam int unsigned POS_W = 12;

  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_MIN_TOUCH = 8'h00;
  localparam logic [7:0] ADDR_MAX_TOUCH = 8'h04;
  localparam logic [7:0] ADDR_TAP_WINDOW = 8'h08;
  localparam logic [7:0] ADDR_MIN_HOLD = 8'h0C;
  localparam logic [7:0] ADDR_MAX_SWIPE = 8'h10;
  localparam logic [7:0] ADDR_MOTION_START = 8'h14;
  localparam logic [7:0] ADDR_SWIPE_TRAVEL = 8'h18;
  localparam logic [7:0] ADDR_SLIDE_STEP = 8'h1C;
  localparam logic [7:0] ADDR_CTRL = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_MASK = 8'h28;
  localparam logic [7:0] ADDR_STATE = 8'h2C;
  localparam logic [7:0] ADDR_SAMPLE_DIV = 8'h30;

  // Control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_DOUBLE_TAP_BIT = 1;
  localparam int unsigned CTRL_POSITIONAL_BIT = 2;

  // Status / mask bit positions
  localparam int unsigned EV_TAP = 0;
  localparam int unsigned EV_DOUBLE_TAP = 1;
  localparam int unsigned EV_HOLD = 2;
  localparam int unsigned EV_SWIPE_UP = 3;
  localparam int unsigned EV_SWIPE_DOWN = 4;
  localparam int unsigned EV_SLIDE_UP = 5;
  localparam int unsigned EV_SLIDE_DOWN = 6;
  localparam int unsigned EV_W = 7;

  // Reset values of the thresholds
  localparam logic [7:0] RST_MIN_TOUCH = 8'h01;
  localparam logic [7:0] RST_MAX_TOUCH = 8'h0F;
  localparam logic [7:0] RST_TAP_WINDOW = 8'h0A;
  localparam logic [7:0] RST_MIN_HOLD = 8'h32;
  localparam logic [7:0] RST_MAX_SWIPE = 8'h0F;
  localparam logic [11:0] RST_MOTION_START = 12'h005;
  localparam logic [11:0] RST_SWIPE_TRAVEL = 12'h032;
  localparam logic [11:0] RST_SLIDE_STEP = 12'h00A;
  localparam logic [2:0] RST_CTRL = 3'h7;

  // Recognizer state
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TOUCH,
    ST_MOTION,
    ST_SLIDING,
    ST_WAIT_SECOND,
    ST_SECOND_TOUCH,
    ST_WAIT_RELEASE
  } gest_state_t;

  // Thresholds carried to the recognizer
  typedef struct packed {
    logic [7:0] min_touch_samples;
    logic [7:0] max_touch_samples;
    logic [7:0] second_tap_window_samples;
    logic [7:0] min_hold_samples;
    logic [7:0] max_swipe_samples;
    logic [11:0] motion_start_distance;
    logic [11:0] min_swipe_travel;
    logic [11:0] slide_step_distance;
    logic double_tap_en;
    logic positional;
  } gest_cfg_t;

  // One sensor measurement sample
  typedef struct packed {
    logic touched;
    logic [11:0] position;
  } gest_sample_t;

endpackage

/* core/gesture_engine.sv */
// Per-sample gesture classification state machine
`timescale 1ns/1ps
module gesture_engine (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire gesture_pkg::gest_sample_t sample_i,
  input wire gesture_pkg::gest_cfg_t cfg_i,
  output logic [gesture_pkg::EV_W-1:0] events_o,
  output gesture_pkg::gest_state_t state_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  gesture_pkg::gest_state_t state_reg, state_next;
  logic [7:0] touch_cnt_reg, touch_cnt_next;   // Samples touched
  logic [7:0] gap_cnt_reg, gap_cnt_next;       // Samples since first tap
  logic [11:0] start_pos_reg, start_pos_next;  // Position at touch-down
  logic [11:0] anchor_reg, anchor_next;        // Position of last slide report
  logic [11:0] last_reg, last_next;  // Last touched position
  logic [gesture_pkg::EV_W-1:0] ev_reg, ev_next;

  // Distance arithmetic
  wire logic [11:0] pos = sample_i.position;
  wire logic up_travel = pos >= start_pos_reg;
  wire logic [11:0] travel = up_travel ? pos - start_pos_reg : start_pos_reg - pos;
  wire logic up_step = pos >= anchor_reg;
  wire logic [11:0] step = up_step ? pos - anchor_reg : anchor_reg - pos;
  // Swipe ends at last touched sample
  wire logic up_swipe = last_reg >= start_pos_reg;
  wire logic [11:0] swipe_len = up_swipe ? last_reg - start_pos_reg : start_pos_reg - last_reg;
  wire logic [7:0] cnt_inc = touch_cnt_reg + 8'h01;
  wire logic min_met = cnt_inc >= cfg_i.min_touch_samples;
  wire logic tap_ok = touch_cnt_reg >= cfg_i.min_touch_samples &&
                      touch_cnt_reg <= cfg_i.max_touch_samples;
  wire logic hold_ok = touch_cnt_reg >= cfg_i.min_touch_samples &&
                       touch_cnt_reg >= cfg_i.min_hold_samples;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic, evaluated once per sample tick
  always_comb begin
    state_next = state_reg;
    touch_cnt_next = touch_cnt_reg;
    gap_cnt_next = gap_cnt_reg;
    start_pos_next = start_pos_reg;
    anchor_next = anchor_reg;
    last_next = (tick_i && sample_i.touched) ? pos : last_reg;
    ev_next = '0;
    if (tick_i) begin
      case (state_reg)
        gesture_pkg::ST_IDLE: begin
          if (sample_i.touched) begin
            state_next = gesture_pkg::ST_TOUCH;
            touch_cnt_next = 8'h01;
            start_pos_next = pos;
            anchor_next = pos;
          end
        end
        gesture_pkg::ST_TOUCH: begin
          if (sample_i.touched) begin
            // Count saturates to keep long holds valid
            if (touch_cnt_reg != 8'hFF) begin
              touch_cnt_next = cnt_inc;
            end
            if (cfg_i.positional && travel >= cfg_i.motion_start_distance) begin
              state_next = gesture_pkg::ST_MOTION;
            end
          end else begin
            // Release: touch count cleared for next touch
            state_next = gesture_pkg::ST_IDLE;
            touch_cnt_next = '0;
            if (hold_ok && touch_cnt_reg > cfg_i.max_touch_samples) begin
              ev_next[gesture_pkg::EV_HOLD] = 1'b1;
            end else if (tap_ok && cfg_i.double_tap_en) begin
              state_next = gesture_pkg::ST_WAIT_SECOND;
              gap_cnt_next = '0;
            end else if (tap_ok) begin
              ev_next[gesture_pkg::EV_TAP] = 1'b1;
            end
          end
        end
        gesture_pkg::ST_MOTION, gesture_pkg::ST_SLIDING: begin
          if (sample_i.touched) begin
            if (touch_cnt_reg != 8'hFF) begin
              touch_cnt_next = cnt_inc;
            end
            // Slide reports need no release
            if (min_met && step >= cfg_i.slide_step_distance) begin
              ev_next[up_step ? gesture_pkg::EV_SLIDE_UP : gesture_pkg::EV_SLIDE_DOWN] = 1'b1;
              anchor_next = pos;
              state_next = gesture_pkg::ST_SLIDING;
            end
          end else begin
            state_next = gesture_pkg::ST_IDLE;
            touch_cnt_next = '0;
            if (state_reg == gesture_pkg::ST_MOTION && swipe_len >= cfg_i.min_swipe_travel &&
                touch_cnt_reg >= cfg_i.min_touch_samples &&
                touch_cnt_reg <= cfg_i.max_swipe_samples) begin
              ev_next[up_swipe ? gesture_pkg::EV_SWIPE_UP : gesture_pkg::EV_SWIPE_DOWN] = 1'b1;
            end
          end
        end
        gesture_pkg::ST_WAIT_SECOND: begin
          gap_cnt_next = gap_cnt_reg + 8'h01;
          if (sample_i.touched) begin
            state_next = gesture_pkg::ST_SECOND_TOUCH;
            touch_cnt_next = 8'h01;
          end else if (gap_cnt_next >= cfg_i.second_tap_window_samples) begin
            // Window expired: the single tap is reported late
            ev_next[gesture_pkg::EV_TAP] = 1'b1;
            state_next = gesture_pkg::ST_IDLE;
          end
        end
        gesture_pkg::ST_SECOND_TOUCH: begin
          if (sample_i.touched) begin
            if (touch_cnt_reg != 8'hFF) begin
              touch_cnt_next = cnt_inc;
            end
          end else begin
            state_next = gesture_pkg::ST_IDLE;
            touch_cnt_next = '0;
            if (tap_ok) begin
              ev_next[gesture_pkg::EV_DOUBLE_TAP] = 1'b1;
            end else begin
              ev_next[gesture_pkg::EV_TAP] = 1'b1;
            end
          end
        end
        default: begin
          state_next = gesture_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= gesture_pkg::ST_IDLE;
      touch_cnt_reg <= '0;
      gap_cnt_reg <= '0;
      start_pos_reg <= '0;
      anchor_reg <= '0;
      last_reg <= '0;
      ev_reg <= '0;
    end else begin
      state_reg <= state_next;
      touch_cnt_reg <= touch_cnt_next;
      gap_cnt_reg <= gap_cnt_next;
      start_pos_reg <= start_pos_next;
      anchor_reg <= anchor_next;
      last_reg <= last_next;
      ev_reg <= ev_next;
    end
  end

  assign events_o = ev_reg;
  assign state_o = state_reg;

endmodule

/* sim/touch_gesture_assertions.sv */
// Concurrent checks on the ports of the touch gesture recognizer
`timescale 1ns/1ps
module touch_gesture_assertions #(
  parameter int unsigned TICK_CYCLES = gesture_pkg::SAMPLE_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic touched_i,
  input wire logic [gesture_pkg::POS_W-1:0] position_i,
  input wire logic sample_tick_o,
  input wire logic [gesture_pkg::EV_W-1:0] gesture_o,
  input wire logic irq_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] gap_cnt; // Cycles since the previous tick
  logic seen_tick; // Set once a first tick has passed
  // Count the spacing of sample ticks
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gap_cnt <= 32'h0000_0000;
      seen_tick <= 1'b0;
    end else if (sample_tick_o) begin
      gap_cnt <= 32'h0000_0000;
      seen_tick <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 32'h0000_0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Evaluation edges with the finger on and off
  sequence s_eval_touched;
    sample_tick_o && touched_i;
  endsequence
  sequence s_eval_released;
    sample_tick_o && !touched_i;
  endsequence
  property p_tick_gap;
    sample_tick_o && seen_tick |-> gap_cnt == TICK_CYCLES - 1;
  endproperty
  property p_tick_pulse;
    sample_tick_o |=> !sample_tick_o;
  endproperty
  property p_gesture_after_tick;
    gesture_o != '0 |-> $past(sample_tick_o);
  endproperty
  property p_gesture_pulse;
    gesture_o != '0 |=> gesture_o == '0;
  endproperty
  property p_tap_on_release;
    not (s_eval_touched ##1 gesture_o[gesture_pkg::EV_TAP]);
  endproperty
  property p_double_on_release;
    not (s_eval_touched ##1 gesture_o[gesture_pkg::EV_DOUBLE_TAP]);
  endproperty
  property p_hold_on_release;
    not (s_eval_touched ##1 gesture_o[gesture_pkg::EV_HOLD]);
  endproperty
  property p_swipe_on_release;
    not (s_eval_touched ##1 (gesture_o[gesture_pkg::EV_SWIPE_UP] || gesture_o[gesture_pkg::EV_SWIPE_DOWN]));
  endproperty
  property p_slide_while_touched;
    not (s_eval_released ##1 (gesture_o[gesture_pkg::EV_SLIDE_UP] || gesture_o[gesture_pkg::EV_SLIDE_DOWN]));
  endproperty
  property p_rdata_idle;
    !$past(rd_i) |-> rdata_o == 32'h0000_0000;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick spacing wrong");
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
  a_gesture_after_tick: assert property (p_gesture_after_tick) else $error("gesture without tick");
  a_gesture_pulse: assert property (p_gesture_pulse) else $error("gesture longer than one cycle");
  a_tap_on_release: assert property (p_tap_on_release) else $error("tap while touched");
  a_double_on_release: assert property (p_double_on_release) else $error("double tap while touched");
  a_hold_on_release: assert property (p_hold_on_release) else $error("hold while touched");
  a_swipe_on_release: assert property (p_swipe_on_release) else $error("swipe while touched");
  a_slide_while_touched: assert property (p_slide_while_touched) else $error("slide on release");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read answer");
endmodule

bind touch_gesture_recognizer touch_gesture_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .touched_i(touched_i), .position_i(position_i), .sample_tick_o(sample_tick_o),
  .gesture_o(gesture_o), .irq_o(irq_o));

/* sim/touch_front_end.sv */
// Model of the capacitive measurement front end: one sample per tick
`timescale 1ns/1ps
module touch_front_end (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic tick_i,
  input wire logic touch_req_i,
  input wire logic [gesture_pkg::POS_W-1:0] pos_req_i,
  output logic touched_o,
  output logic [gesture_pkg::POS_W-1:0] position_o
);
  // New measurement launched at each tick, held until the next one
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      touched_o <= 1'b0;
      position_o <= '0;
    end else if (tick_i) begin
      touched_o <= touch_req_i;
      // No finger: position is meaningless, so it keeps changing
      position_o <= touch_req_i ? pos_req_i : ~position_o;
    end
  end
endmodule

/* sim/touch_gesture_recognizer_test.sv */
// Self-checking bench of the touch gesture recognizer
`timescale 1ns/1ps
module touch_gesture_recognizer_test;
  localparam int unsigned TICKS = 4; // Short sample period for simulation
  logic clk_i;
  logic reset_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  logic touched_i;
  logic [gesture_pkg::POS_W-1:0] position_i;
  logic sample_tick_o;
  logic [gesture_pkg::EV_W-1:0] gesture_o;
  logic irq_o;
  logic touch_req; // Sample wanted from the front end
  logic [gesture_pkg::POS_W-1:0] pos_req;
  logic [gesture_pkg::EV_W-1:0] seen; // Gestures gathered since last clear
  logic clr;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  touch_gesture_recognizer #(.TICK_CYCLES(TICKS)) DUT (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .touched_i(touched_i),
    .position_i(position_i), .sample_tick_o(sample_tick_o), .gesture_o(gesture_o), .irq_o(irq_o));
  touch_front_end u_front (.clk_i(clk_i), .reset_i(reset_i), .tick_i(sample_tick_o), .touch_req_i(touch_req),
    .pos_req_i(pos_req), .touched_o(touched_i), .position_o(position_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Gather gesture pulses; timeout guard
  always @(posedge clk_i) begin
    seen <= clr ? '0 : (seen | gesture_o);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Wait out the last sample, then compare
  task automatic chk_gest(input string name, input logic [gesture_pkg::EV_W-1:0] exp);
    @(posedge clk_i iff sample_tick_o === 1'b1);
    repeat (2) @(posedge clk_i);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [gesture_pkg::EV_W-1:0] ev(input int b);
    logic [gesture_pkg::EV_W-1:0] v;
    v = '0;
    v[b] = 1'b1;
    return v;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    chk_reg($sformatf("reg_%h", a), exp, d);
    @(posedge clk_i);
  endtask
  task automatic clear();
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask
  // Sample launched at the next tick
  task automatic step(input logic t, input logic [gesture_pkg::POS_W-1:0] p);
    touch_req <= t;
    pos_req <= p;
    @(posedge clk_i iff sample_tick_o === 1'b1);
  endtask
  task automatic touch(input int n, input logic [gesture_pkg::POS_W-1:0] p);
    repeat (n) step(1'b1, p);
  endtask
  task automatic chk_irq(input logic exp);
    #1 chk_reg("irq", 32'(exp), 32'(irq_o));
    @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] a[12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h28, 8'h2C, 8'h40};
    logic [7:0] e[12] = '{8'h01, 8'h0F, 8'h0A, 8'h32, 8'h0F, 8'h05, 8'h32, 8'h0A, 8'h07, 8'h00, 8'h00, 8'h00};
    foreach (a[i]) rdchk(a[i], {24'h00_0000, e[i]});
    rdchk(gesture_pkg::ADDR_SAMPLE_DIV, 32'(TICKS));
    wr(8'h40, 32'hFFFF_FFFF);
    wr(gesture_pkg::ADDR_STATE, 32'h0000_0003);
    rdchk(8'h40, 32'h0000_0000);
    rdchk(gesture_pkg::ADDR_STATE, 32'h0000_0000);
  endtask
  task automatic t_tap_hold();
    wr(gesture_pkg::ADDR_CTRL, 32'h0000_0005);
    clear();
    touch(3, 12'h064);
    step(1'b0, 12'h000);
    chk_gest("tap_short", ev(gesture_pkg::EV_TAP));
    clear();
    touch(15, 12'h064);
    step(1'b0, 12'h000);
    chk_gest("tap_at_max", ev(gesture_pkg::EV_TAP));
    clear();
    touch(16, 12'h064);
    step(1'b0, 12'h000);
    chk_gest("tap_too_long", '0);
    wr(gesture_pkg::ADDR_MIN_HOLD, 32'h0000_0014);
    clear();
    touch(19, 12'h064);
    step(1'b0, 12'h000);
    chk_gest("hold_short", '0);
    clear();
    touch(20, 12'h064);
    step(1'b0, 12'h000);
    chk_gest("hold", ev(gesture_pkg::EV_HOLD));
  endtask
  task automatic t_double();
    wr(gesture_pkg::ADDR_CTRL, 32'h0000_0007);
    clear();
    touch(2, 12'h064);
    repeat (5) step(1'b0, 12'h000);
    chk_gest("tap_held_back", '0);
    repeat (10) step(1'b0, 12'h000);
    chk_gest("tap_after_window", ev(gesture_pkg::EV_TAP));
    clear();
    touch(2, 12'h064);
    step(1'b0, 12'h000);
    touch(2, 12'h064);
    step(1'b0, 12'h000);
    chk_gest("double", ev(gesture_pkg::EV_DOUBLE_TAP));
    repeat (12) step(1'b0, 12'h000);
    chk_gest("double_no_tap", ev(gesture_pkg::EV_DOUBLE_TAP));
  endtask
  task automatic t_swipe_slide();
    wr(gesture_pkg::ADDR_CTRL, 32'h0000_0005);
    wr(gesture_pkg::ADDR_SLIDE_STEP, 32'h0000_0200);
    clear();
    step(1'b1, 12'h064);
    step(1'b1, 12'h06A);
    step(1'b1, 12'h082);
    step(1'b1, 12'h0A0);
    step(1'b0, 12'h000);
    chk_gest("swipe_up", ev(gesture_pkg::EV_SWIPE_UP));
    clear();
    step(1'b1, 12'h190);
    step(1'b1, 12'h18A);
    step(1'b1, 12'h172);
    step(1'b1, 12'h154);
    step(1'b0, 12'h000);
    chk_gest("swipe_down", ev(gesture_pkg::EV_SWIPE_DOWN));
    clear();
    step(1'b1, 12'h064);
    step(1'b1, 12'h06A);
    touch(15, 12'h0A0);
    step(1'b0, 12'h000);
    chk_gest("swipe_slow", '0);
    wr(gesture_pkg::ADDR_SLIDE_STEP, 32'h0000_000A);
    clear();
    step(1'b1, 12'h064);
    step(1'b1, 12'h070);
    step(1'b1, 12'h07D);
    step(1'b1, 12'h071);
    chk_gest("slide", ev(gesture_pkg::EV_SLIDE_UP) | ev(gesture_pkg::EV_SLIDE_DOWN));
    repeat (3) step(1'b0, 12'h000);
    wr(gesture_pkg::ADDR_CTRL, 32'h0000_0001);
    clear();
    step(1'b1, 12'h064);
    step(1'b1, 12'h12C);
    step(1'b1, 12'h1F4);
    step(1'b0, 12'h000);
    chk_gest("button_tap", ev(gesture_pkg::EV_TAP));
  endtask
  task automatic t_irq();
    wr(gesture_pkg::ADDR_CTRL, 32'h0000_0005);
    wr(gesture_pkg::ADDR_STATUS, 32'h0000_007F);
    clear();
    touch(2, 12'h064);
    step(1'b0, 12'h000);
    chk_gest("irq_tap", ev(gesture_pkg::EV_TAP));
    rdchk(gesture_pkg::ADDR_STATUS, 32'h0000_0001);
    chk_irq(1'b0);
    wr(gesture_pkg::ADDR_MASK, 32'h0000_0001);
    chk_irq(1'b1);
    wr(gesture_pkg::ADDR_STATUS, 32'h0000_0001);
    chk_irq(1'b0);
    rdchk(gesture_pkg::ADDR_STATUS, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0000_0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    touch_req = 1'b0;
    pos_req = 12'h000;
    clr = 1'b1;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    clr <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_tap_hold();
    t_double();
    t_swipe_slide();
    t_irq();
    results();
  end
endmodule
